// ### bench/gateway_model.sv
`timescale 1ns/1ps
// ****************************************
// Gateway on the far side of the link
// ****************************************
module gateway_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Terminal and bench control
   input wire logic access_tx_en,
   input wire logic [7:0] ans_delay,
   input wire logic [15:0] mask,
   input wire logic reacq_cmd,
   // Messages to the terminal
   output logic assign_valid,
   output logic [15:0] assign_slot_mask,
   output logic [7:0] assign_time_corr,
   output logic [7:0] assign_freq_corr,
   output logic correction_valid,
   output logic [7:0] correction_time,
   output logic [7:0] correction_freq,
   output logic reacq_request
);
   logic was_tx_ff, armed_ff, linked_ff;
   logic [9:0] cnt_ff;
   logic [7:0] wait_ff;

   // Answer a captured burst after a chosen delay, then keep correcting
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {was_tx_ff, armed_ff, linked_ff, assign_valid, correction_valid, reacq_request} <= 6'h00;
         cnt_ff <= 10'h000;
         wait_ff <= 8'h00;
      end else begin
         was_tx_ff <= access_tx_en;
         cnt_ff <= cnt_ff + 10'h001;
         assign_valid <= 1'b0;
         correction_valid <= linked_ff && cnt_ff == 10'h3FF;
         reacq_request <= reacq_cmd;
         if (was_tx_ff && !access_tx_en) begin
            armed_ff <= 1'b1;
            wait_ff <= ans_delay;
         end else if (armed_ff && wait_ff == 8'h00) begin
            assign_valid <= 1'b1;
            armed_ff <= 1'b0;
            linked_ff <= 1'b1;
         end else if (armed_ff) begin
            wait_ff <= wait_ff - 8'h01;
         end
      end
   end

   // Idle message fields wander so stale values never look valid
   assign assign_slot_mask = assign_valid ? mask : ~{cnt_ff, cnt_ff[5:0]};
   assign assign_time_corr = assign_valid ? 8'h05 : cnt_ff[7:0];
   assign assign_freq_corr = assign_valid ? 8'hFB : ~cnt_ff[7:0];
   assign correction_time = correction_valid ? 8'h02 : ~cnt_ff[7:0];
   assign correction_freq = correction_valid ? 8'hFE : cnt_ff[7:0];
endmodule : gateway_model

// ### bench/sync_seq_monitor.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for the sync sequencer
// ****************************************
module sync_seq_monitor #(
   parameter int NUM_CANDIDATES = 4
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Inputs watched
   input wire logic [NUM_CANDIDATES-1:0] sync_word_hit,
   input wire logic reacq_request,
   input wire logic [1:0] tx_mode,
   input wire logic traffic_dual_bpsk,
   // Outputs watched
   input wire logic traffic_tx_en,
   input wire logic access_tx_en,
   input wire logic pi4_qpsk_en,
   input wire logic complex_rand_en,
   input wire logic [1:0] data_mod,
   input wire logic fwd_code_common,
   input wire logic [sync_seq_pkg::SLOT_W-1:0] slot_cnt,
   input wire logic [sync_seq_pkg::FRAME_W-1:0] frame_cnt,
   input wire logic [5:0] seq_state,
   input wire logic mode_refused
);
   logic [10:0] burst_len_ff;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Burst length counter, too long for a repetition
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) burst_len_ff <= 11'h000;
      else if (clk_en) burst_len_ff <= access_tx_en ? burst_len_ff + 11'h001 : 11'h000;
   end

   const_mod_a:
      assert property (pi4_qpsk_en && complex_rand_en) else $error("modulation enables dropped");
   access_mod_a:
      assert property (access_tx_en |-> data_mod == 2'h1) else $error("access burst not dual bpsk");
   traffic_mod_a:
      assert property (traffic_tx_en && seq_state == sync_seq_pkg::ST_TRAFFIC |-> data_mod == {1'b0, traffic_dual_bpsk})
         else $error("traffic modulation wrong");
   access_gate_a:
      assert property ($rose(access_tx_en) |-> $past(seq_state) == sync_seq_pkg::ST_ACCESS
         || ($past(seq_state) == sync_seq_pkg::ST_REACQ && $past(reacq_request))) else $error("access not allowed");
   sync_code_a:
      assert property (fwd_code_common == (slot_cnt == 4'h1 && frame_cnt == 4'h0)) else $error("common code misplaced");
   mode_refuse_a:
      assert property (clk_en && tx_mode == 2'h2 |=> mode_refused && !$rose(access_tx_en) && !$rose(traffic_tx_en))
         else $error("return only mode not refused");
   burst_len_a:
      assert property ($fell(access_tx_en) |-> burst_len_ff == 11'h3C0) else $error("access burst length wrong");
   traffic_frame_a:
      assert property (traffic_tx_en |-> $past(frame_cnt) inside {[4'h1:4'h8]} && $past(tx_mode) == 2'h0)
         else $error("traffic outside traffic frames");
   reacq_stop_a:
      assert property (clk_en && reacq_request |-> ##2 !traffic_tx_en) else $error("traffic not stopped");
   state_hot_a:
      assert property ($onehot(seq_state)) else $error("state not one hot");
   hit_acq_a:
      assert property (seq_state == sync_seq_pkg::ST_UNSYNC && clk_en && |sync_word_hit |=>
         seq_state == sync_seq_pkg::ST_FWD_ACQ) else $error("sync word hit ignored");
endmodule : sync_seq_monitor

bind satellite_link_sync_sequencer sync_seq_monitor #(.NUM_CANDIDATES(NUM_CANDIDATES)) u_monitor (
   .ref_clk, .rst_n, .clk_en, .sync_word_hit, .reacq_request, .tx_mode, .traffic_dual_bpsk, .traffic_tx_en,
   .access_tx_en, .pi4_qpsk_en, .complex_rand_en, .data_mod, .fwd_code_common, .slot_cnt, .frame_cnt,
   .seq_state, .mode_refused);

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic ref_clk, rst_n, clk_en, pilot_lock, broadcast_info_done, burst_done, traffic_dual_bpsk;
   logic access_request, reacq_cmd, assign_valid, correction_valid, reacq_request, traffic_tx_en, access_tx_en;
   logic pi4_qpsk_en, complex_rand_en, fwd_code_common, fwd_synced, sync_lost, mode_refused;
   logic [3:0] sync_word_hit, pilot_code, access_slot, access_rand_offset, access_offset_field, slot_cnt, frame_cnt;
   logic [63:0] sync_word_peak;
   logic [39:0] sync_word_chip;
   logic [9:0] access_advance, chip_cnt;
   logic [7:0] burst_ber, ans_delay, assign_time_corr, assign_freq_corr, correction_time, correction_freq;
   logic [7:0] time_adjust, freq_adjust, exp_t, exp_f;
   logic [15:0] mask, assign_slot_mask;
   logic [1:0] tx_mode, data_mod;
   logic [5:0] seq_state;
   logic [31:0] seed = 32'hc687;
   int mismatches = 0, n_compared = 0, n, bad;

   satellite_link_sync_sequencer uut (.ref_clk, .rst_n, .clk_en, .sync_word_hit, .sync_word_peak, .sync_word_chip,
      .pilot_lock, .pilot_code, .broadcast_info_done, .access_slot, .access_advance, .access_rand_offset,
      .assign_valid, .assign_slot_mask, .assign_time_corr, .assign_freq_corr, .correction_valid, .correction_time,
      .correction_freq, .burst_done, .burst_ber, .reacq_request, .tx_mode, .traffic_dual_bpsk, .access_request,
      .traffic_tx_en, .access_tx_en, .access_offset_field, .pi4_qpsk_en, .complex_rand_en, .data_mod, .time_adjust,
      .freq_adjust, .fwd_code_common, .rand_chip_i(), .rand_chip_q(), .chip_cnt, .slot_cnt, .frame_cnt, .seq_state,
      .fwd_synced, .sync_lost, .mode_refused);
   gateway_model gw (.ref_clk, .rst_n, .access_tx_en, .ans_delay, .mask, .reacq_cmd, .assign_valid,
      .assign_slot_mask, .assign_time_corr, .assign_freq_corr, .correction_valid, .correction_time,
      .correction_freq, .reacq_request);

   // ****************************************
   // Helpers
   // ****************************************
   function logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   // Strongest peak wins; first candidate on a tie
   function automatic logic [31:0] best_chip();
      int b = 0;
      for (int i = 1; i < 4; i++) if (sync_word_peak[i*16+:16] > sync_word_peak[b*16+:16]) b = i;
      return {22'h0, sync_word_chip[b*10+:10]};
   endfunction : best_chip
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic wait_state(input logic [5:0] s);
      for (int i = 0; i < 20000 && seq_state !== s; i++) tick();
      check("seq_state", {26'h0, seq_state}, {26'h0, s});
   endtask : wait_state
   task automatic bursts(input logic [7:0] ber);
      repeat (8) begin
         {burst_done, burst_ber} = {1'b1, ber};
         tick();
         burst_done = 1'b0;
         tick();
      end
   endtask : bursts
   task automatic report_and_stop();
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop

   // Clock and running expectation of the correction accumulators
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (assign_valid) {exp_t, exp_f} = {exp_t + assign_time_corr, exp_f + assign_freq_corr};
      if (correction_valid) {exp_t, exp_f} = {exp_t + correction_time, exp_f + correction_freq};
   end
   // Cut a hang well past the expected 40k cycles
   initial begin
      #800000;
      mismatches++;
      report_and_stop();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rst_n, pilot_lock, broadcast_info_done, burst_done, traffic_dual_bpsk, reacq_cmd, sync_word_hit} = 0;
      {sync_word_peak, sync_word_chip, pilot_code, burst_ber, tx_mode, exp_t, exp_f} = 0;
      clk_en = 1'b1;
      access_request = 1'b1;
      access_slot = 4'h3 + rnd() % 8;
      access_advance = rnd() % 900;
      access_rand_offset = rnd();
      ans_delay = rnd() % 64;
      mask = rnd() | 32'h0100;
      repeat (10) tick();
      check("seq_state", {26'h0, seq_state}, 32'h01);
      rst_n = 1'b1;
      repeat (50) tick();
      check("access_tx_en", {31'h0, access_tx_en}, 32'h0);
      for (int i = 0; i < 4; i++) {sync_word_peak[i*16+:16], sync_word_chip[i*10+:10]} = {rnd(), 10'(rnd() % 900)};
      sync_word_hit = 4'hF;
      tick();
      sync_word_hit = 4'h0;
      check("chip_cnt", {22'h0, chip_cnt}, best_chip());
      check("slot frame", {24'h0, slot_cnt, frame_cnt}, 32'h10);
      check("common code", {31'h0, fwd_code_common}, 32'h1);
      wait_state(6'h02);
      {pilot_lock, pilot_code} = {1'b1, 4'(rnd())};
      wait_state(6'h04);
      broadcast_info_done = 1'b1;
      tick();
      broadcast_info_done = 1'b0;
      wait_state(6'h08);
      check("fwd_synced", {31'h0, fwd_synced}, 32'h1);
      for (int i = 0; i < 20000 && !access_tx_en; i++) tick();
      check("access place", {14'h0, frame_cnt, slot_cnt, chip_cnt}, {14'h0, 4'h0, access_slot,
         10'(access_advance + access_rand_offset + 1)});
      check("offset field", {28'h0, access_offset_field}, {28'h0, access_rand_offset});
      for (n = 0; n < 2000 && access_tx_en; n++) tick();
      check("access length", n, 960);
      wait_state(6'h10);
      traffic_dual_bpsk = rnd();
      for (int i = 0; i < 20000 && !traffic_tx_en; i++) tick();
      check("data_mod", {30'h0, data_mod}, {31'h0, traffic_dual_bpsk});
      // One frame span of slots must match the assignment exactly
      {n, bad} = 0;
      for (int i = 0; i < 15360; i++) begin
         access_slot = slot_cnt;
         tick();
         if (traffic_tx_en) {n, bad} = {n + 1, bad + !mask[access_slot]};
      end
      check("traffic cycles", n, $countones(mask) * 960);
      check("slot misuse", bad, 0);
      check("time_adjust", {24'h0, time_adjust}, {24'h0, exp_t});
      check("freq_adjust", {24'h0, freq_adjust}, {24'h0, exp_f});
      tx_mode = 2'h2;
      repeat (3) tick();
      check("refused", {30'h0, mode_refused, traffic_tx_en}, 32'h2);
      tx_mode = 2'h0;
      repeat (2) tick();
      check("refused", {31'h0, mode_refused}, 32'h0);
      bursts(8'h08);
      check("seq_state", {26'h0, seq_state}, 32'h10);
      bursts(8'hFF);
      repeat (3) tick();
      check("loss", {24'h0, seq_state, sync_lost, traffic_tx_en}, {24'h0, 6'h20, 2'h2});
      n = 0;
      repeat (2000) begin
         tick();
         n += access_tx_en;
      end
      check("unrequested access", n, 0);
      {pilot_lock, reacq_cmd} = 2'h1;
      tick();
      reacq_cmd = 1'b0;
      wait_state(6'h02);
      report_and_stop();
   end
endmodule : testbench

// ### logic/rand_code_gen.sv
`timescale 1ns/1ps
module rand_code_gen (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Control and chips
   rand_code_if.gen rc
);
   logic [sync_seq_pkg::LFSR_W-1:0] lfsr_i_ff;
   logic [sync_seq_pkg::LFSR_W-1:0] lfsr_q_ff;
   logic [sync_seq_pkg::LFSR_W-1:0] seed_i;
   logic [sync_seq_pkg::LFSR_W-1:0] seed_q;

   // Seed offset by code index gives one sequence pair per satellite
   assign seed_i = sync_seq_pkg::LFSR_SEED_I ^ {{(sync_seq_pkg::LFSR_W-sync_seq_pkg::CODE_W){1'b0}}, rc.code_sel};
   assign seed_q = sync_seq_pkg::LFSR_SEED_Q ^ {rc.code_sel, {(sync_seq_pkg::LFSR_W-sync_seq_pkg::CODE_W){1'b0}}};

   // Two Fibonacci registers; restart wins over advance
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_i_ff <= sync_seq_pkg::LFSR_SEED_I;
         lfsr_q_ff <= sync_seq_pkg::LFSR_SEED_Q;
      end else if (clk_en) begin
         if (rc.restart) begin
            lfsr_i_ff <= seed_i;
            lfsr_q_ff <= seed_q;
         end else if (rc.advance) begin
            lfsr_i_ff <= {lfsr_i_ff[16:0], lfsr_i_ff[17] ^ lfsr_i_ff[6]};
            lfsr_q_ff <= {lfsr_q_ff[16:0], lfsr_q_ff[17] ^ lfsr_q_ff[9] ^ lfsr_q_ff[6] ^ lfsr_q_ff[4]};
         end
      end
   end

   assign rc.chip_i = lfsr_i_ff[17];
   assign rc.chip_q = lfsr_q_ff[17];
endmodule : rand_code_gen

// ### logic/satellite_link_sync_sequencer.sv
`timescale 1ns/1ps
module satellite_link_sync_sequencer #(
   parameter int NUM_CANDIDATES = 4,
   parameter int NUM_CODES = 16,
   parameter logic [7:0] BER_THRESHOLD = 8'h20
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Receive-side events from the correlators and demodulator
   input wire logic [NUM_CANDIDATES-1:0] sync_word_hit,
   input wire logic [NUM_CANDIDATES*sync_seq_pkg::PEAK_W-1:0] sync_word_peak,
   input wire logic [NUM_CANDIDATES*sync_seq_pkg::CHIP_W-1:0] sync_word_chip,
   input wire logic pilot_lock,
   input wire logic [sync_seq_pkg::CODE_W-1:0] pilot_code,
   input wire logic broadcast_info_done,
   input wire logic [sync_seq_pkg::FRAME_W-1:0] access_slot,
   input wire logic [sync_seq_pkg::CHIP_W-1:0] access_advance,
   input wire logic [3:0] access_rand_offset,
   input wire logic assign_valid,
   input wire logic [15:0] assign_slot_mask,
   input wire logic [7:0] assign_time_corr,
   input wire logic [7:0] assign_freq_corr,
   input wire logic correction_valid,
   input wire logic [7:0] correction_time,
   input wire logic [7:0] correction_freq,
   input wire logic burst_done,
   input wire logic [sync_seq_pkg::BER_W-1:0] burst_ber,
   input wire logic reacq_request,
   // Configuration
   input wire logic [1:0] tx_mode,
   input wire logic traffic_dual_bpsk,
   input wire logic access_request,
   // Transmit control
   output logic traffic_tx_en,
   output logic access_tx_en,
   output logic [3:0] access_offset_field,
   output logic pi4_qpsk_en,
   output logic complex_rand_en,
   output logic [1:0] data_mod,
   output logic [7:0] time_adjust,
   output logic [7:0] freq_adjust,
   output logic fwd_code_common,
   output logic rand_chip_i,
   output logic rand_chip_q,
   // Status
   output logic [sync_seq_pkg::CHIP_W-1:0] chip_cnt,
   output logic [sync_seq_pkg::SLOT_W-1:0] slot_cnt,
   output logic [sync_seq_pkg::FRAME_W-1:0] frame_cnt,
   output logic [5:0] seq_state,
   output logic fwd_synced,
   output logic sync_lost,
   output logic mode_refused
);
   // ****************************************
   // Declarations
   // ****************************************
   sync_seq_pkg::seq_state_e state_ff;
   sync_seq_pkg::seq_state_e nxt_state;
   logic [sync_seq_pkg::CHIP_W-1:0] chip_ff;
   logic [sync_seq_pkg::SLOT_W-1:0] slot_ff;
   logic [sync_seq_pkg::FRAME_W-1:0] frame_ff;
   logic [sync_seq_pkg::CODE_W-1:0] code_ff;
   logic [15:0] slot_mask_ff;
   logic [7:0] time_adj_ff;
   logic [7:0] freq_adj_ff;
   logic [3:0] offset_ff;
   logic [7:0] ber_acc_ff;
   logic [2:0] ber_cnt_ff;
   logic lost_ff;
   logic refused_ff;
   logic access_sent_ff;
   logic access_active_ff;
   logic [sync_seq_pkg::CHIP_W-1:0] access_chip_ff;
   logic traffic_ff;
   logic access_ff;
   logic best_hit;
   logic [sync_seq_pkg::CHIP_W-1:0] best_chip;
   logic [sync_seq_pkg::PEAK_W-1:0] best_peak;
   logic frame_wrap;
   logic slot_wrap;
   logic code_origin;
   logic access_start;
   logic loss_event;
   logic in_sync_slot;
   logic mode_ok;
   logic [sync_seq_pkg::PEAK_W-1:0] peak_at [NUM_CANDIDATES];
   logic [sync_seq_pkg::CHIP_W-1:0] chip_at [NUM_CANDIDATES];

   rand_code_if rc ();

   // ****************************************
   // Mode check
   // ****************************************
   // No corrections could reach the unit in return-only mode
   assign mode_ok = (tx_mode != sync_seq_pkg::TX_MODE_RET_ONLY);

   // ****************************************
   // Chip, slot and frame counters
   // ****************************************
   assign slot_wrap = (chip_ff == 10'(sync_seq_pkg::CHIPS_PER_SLOT - 1));
   assign frame_wrap = slot_wrap && (slot_ff == 4'(sync_seq_pkg::SLOTS_PER_FRAME - 1));
   assign in_sync_slot = (frame_ff == 4'(sync_seq_pkg::SYNC_FRAME)) && (slot_ff == 4'(sync_seq_pkg::SYNC_SLOT));

   // Sync word picks chip position; otherwise chips, slots and frames count freely
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chip_ff <= '0;
         slot_ff <= '0;
         frame_ff <= '0;
      end else if (clk_en) begin
         if (state_ff == sync_seq_pkg::ST_UNSYNC && best_hit) begin
            // Word lies in slot 1 frame 0; realign to the winning candidate's chip
            chip_ff <= best_chip;
            slot_ff <= 4'(sync_seq_pkg::SYNC_SLOT);
            frame_ff <= 4'(sync_seq_pkg::SYNC_FRAME);
         end else if (slot_wrap) begin
            chip_ff <= '0;
            if (slot_ff == 4'(sync_seq_pkg::SLOTS_PER_FRAME - 1)) begin
               slot_ff <= '0;
               frame_ff <= (frame_ff == 4'(sync_seq_pkg::FRAMES_PER_MULTI - 1)) ? '0 : frame_ff + 4'h1;
            end else begin
               slot_ff <= slot_ff + 4'h1;
            end
         end else begin
            chip_ff <= chip_ff + 10'h001;
         end
      end
   end

   // ****************************************
   // Strongest sync word among candidates
   // ****************************************
   generate
      for (genvar g = 0; g < NUM_CANDIDATES; g++) begin : g_cand
         assign peak_at[g] = sync_word_peak[g*sync_seq_pkg::PEAK_W +: sync_seq_pkg::PEAK_W];
         assign chip_at[g] = sync_word_chip[g*sync_seq_pkg::CHIP_W +: sync_seq_pkg::CHIP_W];
      end
   endgenerate

   // Largest peak wins; lower index wins a tie
   always_comb begin
      best_hit = 1'b0;
      best_peak = '0;
      best_chip = '0;
      for (int k = 0; k < NUM_CANDIDATES; k++) begin
         if (sync_word_hit[k] && (!best_hit || peak_at[k] > best_peak)) begin
            best_hit = 1'b1;
            best_peak = peak_at[k];
            best_chip = chip_at[k];
         end
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   assign loss_event = lost_ff || reacq_request;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         sync_seq_pkg::ST_UNSYNC: if (best_hit) nxt_state = sync_seq_pkg::ST_FWD_ACQ;
         sync_seq_pkg::ST_FWD_ACQ: if (pilot_lock) nxt_state = sync_seq_pkg::ST_SYSINFO;
         sync_seq_pkg::ST_SYSINFO: if (broadcast_info_done) nxt_state = sync_seq_pkg::ST_ACCESS;
         sync_seq_pkg::ST_ACCESS: begin
            if (assign_valid && access_sent_ff) nxt_state = sync_seq_pkg::ST_TRAFFIC;
         end
         sync_seq_pkg::ST_TRAFFIC: if (loss_event) nxt_state = sync_seq_pkg::ST_REACQ;
         sync_seq_pkg::ST_REACQ: begin
            if (!pilot_lock) nxt_state = sync_seq_pkg::ST_FWD_ACQ;
            else if (assign_valid && access_sent_ff) nxt_state = sync_seq_pkg::ST_TRAFFIC;
         end
         default: nxt_state = sync_seq_pkg::ST_UNSYNC;
      endcase
   end

   // Explicit six-state sequencer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= sync_seq_pkg::ST_UNSYNC;
      end else if (clk_en) begin
         state_ff <= nxt_state;
      end
   end

   // Code index captured at pilot lock
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         code_ff <= '0;
      end else if (clk_en && state_ff == sync_seq_pkg::ST_FWD_ACQ && pilot_lock) begin
         if (32'(pilot_code) < NUM_CODES) code_ff <= pilot_code;
      end
   end

   // ****************************************
   // Access burst timing
   // ****************************************
   // Burst starts in frame 0 at the advanced chip plus random offset in the given slot
   assign access_start = clk_en && mode_ok && !access_sent_ff && !access_active_ff
      && (frame_ff == 4'(sync_seq_pkg::SYNC_FRAME)) && (slot_ff == access_slot)
      && (chip_ff == access_advance + 10'(access_rand_offset))
      && ((state_ff == sync_seq_pkg::ST_ACCESS && access_request)
         || (state_ff == sync_seq_pkg::ST_REACQ && reacq_request && pilot_lock));

   // One-slot access burst, once per attempt
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         access_active_ff <= 1'b0;
         access_sent_ff <= 1'b0;
         access_chip_ff <= '0;
         offset_ff <= '0;
      end else if (clk_en) begin
         if (access_start) begin
            access_active_ff <= 1'b1;
            access_chip_ff <= '0;
            offset_ff <= access_rand_offset;
         end else if (access_active_ff) begin
            if (access_chip_ff == 10'(sync_seq_pkg::CHIPS_PER_SLOT - 1)) begin
               access_active_ff <= 1'b0;
               access_sent_ff <= 1'b1;
            end
            access_chip_ff <= access_chip_ff + 10'h001;
         end
         if (nxt_state == sync_seq_pkg::ST_TRAFFIC || nxt_state == sync_seq_pkg::ST_FWD_ACQ) begin
            access_sent_ff <= 1'b0;
         end
      end
   end

   // ****************************************
   // Assignment and corrections
   // ****************************************
   // Assignment loads slots and adds its offsets; commands accumulate in traffic
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_mask_ff <= '0;
         time_adj_ff <= '0;
         freq_adj_ff <= '0;
      end else if (clk_en) begin
         if (assign_valid && access_sent_ff) begin
            slot_mask_ff <= assign_slot_mask;
            time_adj_ff <= time_adj_ff + assign_time_corr;
            freq_adj_ff <= freq_adj_ff + assign_freq_corr;
         end else if (correction_valid && state_ff == sync_seq_pkg::ST_TRAFFIC) begin
            time_adj_ff <= time_adj_ff + correction_time;
            freq_adj_ff <= freq_adj_ff + correction_freq;
         end
      end
   end

   // ****************************************
   // Burst error monitor
   // ****************************************
   // Average over eight bursts; loss is sticky until traffic restarts
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ber_acc_ff <= '0;
         ber_cnt_ff <= '0;
         lost_ff <= 1'b0;
      end else if (clk_en) begin
         if (state_ff != sync_seq_pkg::ST_TRAFFIC) begin
            ber_acc_ff <= '0;
            ber_cnt_ff <= '0;
            if (nxt_state == sync_seq_pkg::ST_TRAFFIC) lost_ff <= 1'b0;
         end else if (burst_done) begin
            if (ber_cnt_ff == 3'h7) begin
               lost_ff <= ({1'b0, ber_acc_ff} + {4'h0, burst_ber[7:3]}) > {2'h0, BER_THRESHOLD[7:1]};
               ber_acc_ff <= '0;
            end else begin
               ber_acc_ff <= ber_acc_ff + {3'h0, burst_ber[7:3]};
            end
            ber_cnt_ff <= ber_cnt_ff + 3'h1;
         end
      end
   end

   // Refused mode flag
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         refused_ff <= 1'b0;
      end else if (clk_en) begin
         refused_ff <= !mode_ok;
      end
   end

   // ****************************************
   // Transmit gating
   // ****************************************
   // Traffic stops on the clock after loss is seen
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         traffic_ff <= 1'b0;
         access_ff <= 1'b0;
      end else if (clk_en) begin
         traffic_ff <= (nxt_state == sync_seq_pkg::ST_TRAFFIC) && !loss_event && mode_ok
            && (tx_mode == sync_seq_pkg::TX_MODE_TWO_WAY) && (frame_ff != 4'(sync_seq_pkg::SYNC_FRAME))
            && slot_mask_ff[slot_ff];
         access_ff <= access_start || (access_active_ff && access_chip_ff != 10'(sync_seq_pkg::CHIPS_PER_SLOT - 1));
      end
   end

   // ****************************************
   // Randomization code control
   // ****************************************
   assign code_origin = in_sync_slot && (chip_ff == '0);
   assign rc.code_sel = code_ff;
   // Restart at slot 1 frame 0 unless an access burst is active, or at an async access burst's first chip
   assign rc.restart = (code_origin && !access_active_ff) || access_start;
   // Free-running: no pause in sync bursts or async frames
   assign rc.advance = 1'b1;

   rand_code_gen u_code (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .rc(rc)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign traffic_tx_en = traffic_ff;
   assign access_tx_en = access_ff;
   assign access_offset_field = offset_ff;
   assign pi4_qpsk_en = 1'b1;
   assign complex_rand_en = 1'b1;
   // Access burst always dual BPSK
   assign data_mod = (access_ff || traffic_dual_bpsk) ? sync_seq_pkg::MOD_DUAL_BPSK : sync_seq_pkg::MOD_QPSK;
   assign time_adjust = time_adj_ff;
   assign freq_adjust = freq_adj_ff;
   assign fwd_code_common = in_sync_slot;
   assign rand_chip_i = rc.chip_i;
   assign rand_chip_q = rc.chip_q;
   assign chip_cnt = chip_ff;
   assign slot_cnt = slot_ff;
   assign frame_cnt = frame_ff;
   assign seq_state = state_ff;
   assign fwd_synced = (state_ff == sync_seq_pkg::ST_ACCESS) || (state_ff == sync_seq_pkg::ST_TRAFFIC);
   assign sync_lost = lost_ff;
   assign mode_refused = refused_ff;
endmodule : satellite_link_sync_sequencer

// ### pkg/rand_code_if.sv
`timescale 1ns/1ps
interface rand_code_if;
   logic restart;
   logic advance;
   logic [sync_seq_pkg::CODE_W-1:0] code_sel;
   logic chip_i;
   logic chip_q;
   modport gen (input restart, input advance, input code_sel, output chip_i, output chip_q);
   modport user (output restart, output advance, output code_sel, input chip_i, input chip_q);
endinterface : rand_code_if

// ### pkg/sync_seq_pkg.sv
package sync_seq_pkg;
   // ****************************************
   // Framing and timing
   // ****************************************
   localparam int CHIPS_PER_SLOT = 960;
   localparam int SLOTS_PER_FRAME = 16;
   localparam int FRAMES_PER_MULTI = 9;
   localparam int SYNC_WORD_CHIPS = 960;
   localparam int SYNC_SLOT = 1;
   localparam int SYNC_FRAME = 0;
   localparam int CHIP_W = 10;
   localparam int SLOT_W = 4;
   localparam int FRAME_W = 4;
   localparam int PEAK_W = 16;
   localparam int CODE_W = 4;
   localparam int LFSR_W = 18;
   localparam logic [LFSR_W-1:0] LFSR_SEED_I = 18'h00001;
   localparam logic [LFSR_W-1:0] LFSR_SEED_Q = 18'h3FFFF;
   localparam int BER_W = 8;

   // ****************************************
   // Modulation and mode encodings
   // ****************************************
   typedef enum logic [1:0] {
      MOD_QPSK = 2'h0,
      MOD_DUAL_BPSK = 2'h1
   } data_mod_e;

   typedef enum logic [1:0] {
      TX_MODE_TWO_WAY = 2'h0,
      TX_MODE_FWD_ONLY = 2'h1,
      TX_MODE_RET_ONLY = 2'h2
   } tx_mode_e;

   typedef enum logic [5:0] {
      ST_UNSYNC = 6'h01,
      ST_FWD_ACQ = 6'h02,
      ST_SYSINFO = 6'h04,
      ST_ACCESS = 6'h08,
      ST_TRAFFIC = 6'h10,
      ST_REACQ = 6'h20
   } seq_state_e;
endpackage : sync_seq_pkg
